// >>> core/rcs_pkg.sv
// constants and state types for the clock control and status registers
package rcs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] CLOCK_CONTROL_OFFSET = 8'h0E;
    localparam logic [7:0] CLOCK_STATUS_OFFSET = 8'h0F;

    ////////////////////////////////////////////////////////////////////////
    // clock_control field positions
    localparam int CTRL_OSC_DISABLE_BIT = 7;
    localparam int CTRL_BACKUP_SQW_BIT = 6;
    localparam int CTRL_FORCE_FORCE_TEMP_CONVERSION_BIT = 5;
    localparam int CTRL_SPARE_HI_BIT = 4;
    localparam int CTRL_SPARE_LO_BIT = 3;
    localparam int CTRL_PIN_FUNC_BIT = 2;
    localparam int CTRL_SECOND_IE_BIT = 1;
    localparam int CTRL_FIRST_IE_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // clock_status field positions
    localparam int STAT_OSC_STOPPED_BIT = 7;
    localparam int STAT_SLOW_CLK_EN_BIT = 3;
    localparam int STAT_FORCE_TEMP_CONVERSION_BUSY_BIT = 2;
    localparam int STAT_SECOND_FLAG_BIT = 1;
    localparam int STAT_FIRST_FLAG_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // values after reset and for unmapped reads
    localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h1C;
    localparam logic OSC_STOPPED_RESET = 1'h1;
    localparam logic SLOW_CLK_EN_RESET = 1'h1;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer states
    typedef enum logic [0:0] {
        RCS_IDLE = 1'h0,
        RCS_CONVERT = 1'h1
    } rcs_force_temp_conversion_fsm_t;

    // complete state of the conversion sequencer
    typedef struct packed {
        rcs_force_temp_conversion_fsm_t fsm;
        logic force_pending;
        logic periodic_pending;
        logic running_forced;
        logic comp_owed;
        logic comp_used;
        logic sensor_start;
        logic comp_update;
    } rcs_force_temp_conversion_state_t;

    // complete state of the register block
    typedef struct packed {
        logic [7:0] ctrl;
        logic osc_stopped;
        logic slow_clk_en;
        logic second_flag;
        logic first_flag;
        logic run_meta;
        logic run_sync;
        logic pf_meta;
        logic pf_sync;
        logic bk_meta;
        logic bk_sync;
        logic sf_meta;
        logic sf_sync;
        logic osc_enable;
        logic counters_hold;
        logic [7:0] rdata;
        logic rvalid;
        logic irq_oe_n;
        logic slow_out;
        logic slow_oe_n;
    } rcs_regs_state_t;

endpackage : rcs_pkg

// >>> core/rcs_force_temp_conversion_seq.sv
// temperature conversion sequencer with once-per-second compensation limit
`timescale 1ns/100ps

module rcs_force_temp_conversion_seq (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // requests
    input wire logic force_req,
    input wire logic periodic_req,
    input wire logic update_tick,
    // temperature sensor
    input wire logic force_temp_conversion_done,
    output logic sensor_start,
    output logic comp_update,
    // status
    output logic busy,
    output logic force_active
);

    rcs_pkg::rcs_force_temp_conversion_state_t cur;
    rcs_pkg::rcs_force_temp_conversion_state_t next;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next = cur;
        next.sensor_start = 1'h0;
        next.comp_update = 1'h0;
        // requests are latched; set wins over consumption
        if (cur.fsm == rcs_pkg::RCS_IDLE && (cur.force_pending || cur.periodic_pending)) begin
            next.fsm = rcs_pkg::RCS_CONVERT;
            next.sensor_start = 1'h1; // busy rises with the start pulse
            next.running_forced = cur.force_pending;
            next.force_pending = 1'h0;
            next.periodic_pending = 1'h0;
        end
        if (cur.fsm == rcs_pkg::RCS_CONVERT && force_temp_conversion_done) begin
            next.fsm = rcs_pkg::RCS_IDLE; // busy and force bit fall together
            next.running_forced = 1'h0;
            next.comp_owed = 1'h1;
        end
        // periodic request waits out a forced run, schedule untouched
        if (periodic_req) begin
            next.periodic_pending = 1'h1;
        end
        if (force_req) begin
            next.force_pending = 1'h1;
        end
        // compensation at most once per update second
        if (update_tick) begin
            next.comp_used = 1'h0;
        end
        if (cur.comp_owed && (!cur.comp_used || update_tick)) begin
            next.comp_update = 1'h1;
            next.comp_used = 1'h1;
            next.comp_owed = 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cur <= '0;
        end else begin
            cur <= next;
        end
    end

    // outputs from flip-flops; force_active is the OR of two of them
    assign sensor_start = cur.sensor_start;
    assign comp_update = cur.comp_update;
    assign busy = (cur.fsm == rcs_pkg::RCS_CONVERT);
    assign force_active = cur.force_pending | cur.running_forced;

endmodule : rcs_force_temp_conversion_seq

// >>> core/rcs_regs.sv
// clock control and status registers, pin functions and oscillator control
`timescale 1ns/100ps

module rcs_regs (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    // timekeeping core, same clock
    input wire logic update_tick,
    input wire logic first_alarm_match,
    input wire logic second_alarm_match,
    input wire logic one_hz_wave,
    input wire logic slow_clock_wave,
    input wire logic periodic_force_temp_conversion_req,
    output logic counters_hold,
    // oscillator and supplies, asynchronous
    input wire logic osc_running,
    input wire logic main_below_pf,
    input wire logic on_backup_supply,
    input wire logic supply_insufficient,
    output logic osc_enable,
    // temperature sensor and compensation
    input wire logic temp_force_temp_conversion_done,
    output logic temp_force_temp_conversion_start,
    output logic comp_update,
    // shared interrupt or square-wave pin, open drain
    output logic irq_or_square_wave_pin_out,
    output logic irq_or_square_wave_pin_oe_n,
    // slow clock pin
    output logic slow_clock_pin_out,
    output logic slow_clock_pin_oe_n
);

    rcs_pkg::rcs_regs_state_t cur;
    rcs_pkg::rcs_regs_state_t next;

    logic wr_ctrl;
    logic wr_stat;
    logic rd_ctrl;
    logic rd_stat;
    logic force_req;
    logic force_temp_conversion_busy;
    logic force_temp_conversion_force_active;
    logic alarm_update;
    logic irq_active;
    logic sqw_allowed;
    logic [7:0] ctrl_view;
    logic [7:0] stat_view;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    assign wr_ctrl = reg_wr_en && (reg_addr == rcs_pkg::CLOCK_CONTROL_OFFSET);
    assign wr_stat = reg_wr_en && (reg_addr == rcs_pkg::CLOCK_STATUS_OFFSET);
    assign rd_ctrl = reg_rd_en && (reg_addr == rcs_pkg::CLOCK_CONTROL_OFFSET);
    assign rd_stat = reg_rd_en && (reg_addr == rcs_pkg::CLOCK_STATUS_OFFSET);

    // writing 1 to the force bit requests a conversion; writing 0 does nothing
    assign force_req = wr_ctrl && reg_wdata[rcs_pkg::CTRL_FORCE_FORCE_TEMP_CONVERSION_BIT];

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer
    rcs_force_temp_conversion_seq u_force_temp_conversion_seq (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .force_req(force_req),
        .periodic_req(periodic_force_temp_conversion_req),
        .update_tick(update_tick),
        .force_temp_conversion_done(temp_force_temp_conversion_done),
        .sensor_start(temp_force_temp_conversion_start),
        .comp_update(comp_update),
        .busy(force_temp_conversion_busy),
        .force_active(force_temp_conversion_force_active)
    );

    ////////////////////////////////////////////////////////////////////////
    // read views of the two registers
    always_comb begin
        ctrl_view = cur.ctrl;
        ctrl_view[rcs_pkg::CTRL_FORCE_FORCE_TEMP_CONVERSION_BIT] = force_temp_conversion_force_active;
        stat_view = 8'h00; // unused bits fixed low
        stat_view[rcs_pkg::STAT_OSC_STOPPED_BIT] = cur.osc_stopped;
        stat_view[rcs_pkg::STAT_SLOW_CLK_EN_BIT] = cur.slow_clk_en;
        stat_view[rcs_pkg::STAT_FORCE_TEMP_CONVERSION_BUSY_BIT] = force_temp_conversion_busy;
        stat_view[rcs_pkg::STAT_SECOND_FLAG_BIT] = cur.second_flag;
        stat_view[rcs_pkg::STAT_FIRST_FLAG_BIT] = cur.first_flag;
    end

    // matches only count at the once-per-second update, never while frozen
    assign alarm_update = update_tick && !cur.counters_hold;

    // enabled flags gate the interrupt, pin select must be 1
    assign irq_active = cur.ctrl[rcs_pkg::CTRL_PIN_FUNC_BIT]
        && ((cur.first_flag && cur.ctrl[rcs_pkg::CTRL_FIRST_IE_BIT])
        || (cur.second_flag && cur.ctrl[rcs_pkg::CTRL_SECOND_IE_BIT]));

    // square wave survives low main supply only with backup enable
    assign sqw_allowed = !cur.pf_sync || cur.ctrl[rcs_pkg::CTRL_BACKUP_SQW_BIT];

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next = cur;

        // two-stage synchronisers for the analogue-side levels
        next.run_meta = osc_running;
        next.run_sync = cur.run_meta;
        next.pf_meta = main_below_pf;
        next.pf_sync = cur.pf_meta;
        next.bk_meta = on_backup_supply;
        next.bk_sync = cur.bk_meta;
        next.sf_meta = supply_insufficient;
        next.sf_sync = cur.sf_meta;

        // control register; bits 4 and 3 are stored but steer nothing
        if (wr_ctrl) begin
            next.ctrl = reg_wdata;
            next.ctrl[rcs_pkg::CTRL_FORCE_FORCE_TEMP_CONVERSION_BIT] = 1'h0; // held by the sequencer
        end

        // slow clock enable is plain read and write
        if (wr_stat) begin
            next.slow_clk_en = reg_wdata[rcs_pkg::STAT_SLOW_CLK_EN_BIT];
        end

        // stopped flag: write 0 clears, write 1 ignored
        if (wr_stat && !reg_wdata[rcs_pkg::STAT_OSC_STOPPED_BIT]) begin
            next.osc_stopped = 1'h0;
        end
        // any stop condition sets it; set wins over the clear
        if (!cur.run_sync || cur.sf_sync || !cur.osc_enable) begin
            next.osc_stopped = 1'h1;
        end

        // alarm flags: write 0 clears, write 1 leaves unchanged
        if (wr_stat && !reg_wdata[rcs_pkg::STAT_SECOND_FLAG_BIT]) begin
            next.second_flag = 1'h0;
        end
        if (wr_stat && !reg_wdata[rcs_pkg::STAT_FIRST_FLAG_BIT]) begin
            next.first_flag = 1'h0;
        end
        // match sets regardless of enables or pin select; set wins
        if (alarm_update && second_alarm_match) begin
            next.second_flag = 1'h1;
        end
        if (alarm_update && first_alarm_match) begin
            next.first_flag = 1'h1;
        end

        // oscillator may only stop while on backup supply
        next.osc_enable = !(cur.ctrl[rcs_pkg::CTRL_OSC_DISABLE_BIT] && cur.bk_sync);

        // freeze counters whenever the oscillator is not running
        next.counters_hold = !cur.run_sync || !cur.osc_enable;

        // registered read answer, zero for unmapped offsets
        next.rvalid = reg_rd_en;
        if (rd_ctrl) begin
            next.rdata = ctrl_view;
        end else if (rd_stat) begin
            next.rdata = stat_view;
        end else if (reg_rd_en) begin
            next.rdata = rcs_pkg::READ_UNMAPPED;
        end

        // shared pin: floats on low main supply without backup enable, in either mode
        if (!sqw_allowed) begin
            next.irq_oe_n = 1'h1;
        end else if (cur.ctrl[rcs_pkg::CTRL_PIN_FUNC_BIT]) begin
            next.irq_oe_n = !irq_active;
        end else begin
            next.irq_oe_n = one_hz_wave;
        end

        // slow clock pin floats unless enabled; wave only while running
        next.slow_oe_n = !cur.slow_clk_en;
        next.slow_out = slow_clock_wave && cur.run_sync;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register with power-up values
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cur <= '0;
            cur.ctrl <= rcs_pkg::CLOCK_CONTROL_RESET;
            cur.osc_stopped <= rcs_pkg::OSC_STOPPED_RESET;
            cur.slow_clk_en <= rcs_pkg::SLOW_CLK_EN_RESET;
            cur.osc_enable <= 1'h1;
            cur.run_meta <= 1'h1; // no false counter freeze right after reset
            cur.run_sync <= 1'h1;
            cur.irq_oe_n <= 1'h1;
            cur.slow_oe_n <= 1'h1;
        end else begin
            cur <= next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata = cur.rdata;
    assign reg_rd_valid = cur.rvalid;
    assign counters_hold = cur.counters_hold;
    assign osc_enable = cur.osc_enable;
    assign irq_or_square_wave_pin_out = 1'h0; // open drain, level always low
    assign irq_or_square_wave_pin_oe_n = cur.irq_oe_n;
    assign slow_clock_pin_out = cur.slow_out;
    assign slow_clock_pin_oe_n = cur.slow_oe_n;

endmodule : rcs_regs

// >>> verif/rcs_regs_monitor.sv
// port assertions for the clock control and status registers
`timescale 1ns/100ps

module rcs_regs_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    // core, oscillator and sensor
    input wire logic update_tick,
    input wire logic on_backup_supply,
    input wire logic osc_running,
    input wire logic osc_enable,
    input wire logic counters_hold,
    input wire logic temp_force_temp_conversion_start,
    input wire logic comp_update,
    input wire logic slow_clock_wave,
    input wire logic slow_clock_pin_out,
    input wire logic irq_or_square_wave_pin_oe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic comp_seen;

    // remembers a compensation update since the last tick
    always_ff @(posedge sys_clk) begin
        if (!resetn || update_tick) begin
            comp_seen <= 1'h0;
        end else if (comp_update) begin
            comp_seen <= 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_status_zero: assert property (
        reg_rd_en && reg_addr == 8'h0F |=> reg_rd_valid && reg_rdata[6:4] == 3'h0)
        else $error("status bits 6 to 4 not zero");
    chk_comp_rate: assert property (comp_update && !update_tick |-> !comp_seen)
        else $error("second compensation update in one tick window");
    chk_main_osc_on: assert property (!on_backup_supply [*4] |-> osc_enable)
        else $error("oscillator disabled on main supply");
    chk_backup_only: assert property (
        !osc_enable |-> $past(on_backup_supply, 3) || $past(on_backup_supply, 2))
        else $error("oscillator disabled without backup supply");
    chk_stop_hold: assert property (!osc_running [*4] |-> counters_hold)
        else $error("counters not held with oscillator stopped");
    chk_slow_wave: assert property (slow_clock_pin_out |-> $past(slow_clock_wave))
        else $error("slow clock pin high without wave");
    chk_slow_stopped: assert property (!osc_running [*4] |-> !slow_clock_pin_out)
        else $error("slow clock pin toggles with oscillator stopped");
    chk_force_temp_conversion_pulse: assert property (temp_force_temp_conversion_start |=> !temp_force_temp_conversion_start)
        else $error("conversion start longer than one cycle");

    // main scenarios
    cov_comp: cover property (comp_update);
    cov_irq: cover property ($fell(irq_or_square_wave_pin_oe_n));
    cov_hold: cover property (counters_hold);
    cov_start: cover property (temp_force_temp_conversion_start);
endmodule : rcs_regs_monitor

bind rcs_regs rcs_regs_monitor mon (.sys_clk, .resetn, .reg_rd_en, .reg_addr, .reg_rdata, .reg_rd_valid,
    .update_tick, .on_backup_supply, .osc_running, .osc_enable, .counters_hold, .temp_force_temp_conversion_start,
    .comp_update, .slow_clock_wave, .slow_clock_pin_out, .irq_or_square_wave_pin_oe_n);

// >>> verif/rcs_core_model.sv
// oscillator, wave sources and temperature sensor beside the registers
`timescale 1ns/100ps

module rcs_core_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // bench controls
    input wire logic slow_done,
    input wire logic supply_insufficient,
    // oscillator and sensor
    input wire logic osc_enable,
    input wire logic temp_force_temp_conversion_start,
    output logic osc_running,
    output logic temp_force_temp_conversion_done,
    // waves from the time base
    output logic one_hz_wave,
    output logic slow_clock_wave
);
    logic [4:0] wait_cnt;
    logic [1:0] div;

    // waves advance only while the oscillator runs
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            div <= 2'h0;
            one_hz_wave <= 1'h0;
            slow_clock_wave <= 1'h0;
        end else if (osc_running) begin
            div <= div + 2'h1;
            slow_clock_wave <= ~slow_clock_wave;
            one_hz_wave <= (div == 2'h3) ? ~one_hz_wave : one_hz_wave;
        end
    end

    // oscillator follows enable; sensor answers promptly or slowly
    always_ff @(posedge sys_clk) begin
        osc_running <= osc_enable && !supply_insufficient;
        temp_force_temp_conversion_done <= wait_cnt == 5'h01;
        if (!resetn) begin
            wait_cnt <= 5'h00;
        end else if (temp_force_temp_conversion_start) begin
            wait_cnt <= slow_done ? 5'h14 : 5'h03;
        end else if (wait_cnt != 5'h00) begin
            wait_cnt <= wait_cnt - 5'h01;
        end
    end
endmodule : rcs_core_model

// >>> verif/rcs_regs_test.sv
// self-checking bench for the clock control and status registers
`timescale 1ns/100ps

module rcs_regs_test;
    logic sys_clk = 1'h0, resetn = 1'h0, reg_wr_en = 1'h0, reg_rd_en = 1'h0, reg_rd_valid;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
    logic update_tick = 1'h0, first_alarm_match = 1'h0, second_alarm_match = 1'h0;
    logic one_hz_wave, slow_clock_wave, periodic_force_temp_conversion_req = 1'h0, counters_hold, osc_running;
    logic main_below_pf = 1'h0, on_backup_supply = 1'h0, supply_insufficient = 1'h0, slow_done = 1'h0;
    logic osc_enable, temp_force_temp_conversion_done, temp_force_temp_conversion_start, comp_update, slow_clock_pin_out, slow_clock_pin_oe_n;
    logic irq_or_square_wave_pin_out, irq_or_square_wave_pin_oe_n;
    int bad_count = 0, check_count = 0, comps = 0;

    rcs_regs uut (.sys_clk, .resetn, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
        .update_tick, .first_alarm_match, .second_alarm_match, .one_hz_wave, .slow_clock_wave, .periodic_force_temp_conversion_req,
        .counters_hold, .osc_running, .main_below_pf, .on_backup_supply, .supply_insufficient, .osc_enable,
        .temp_force_temp_conversion_done, .temp_force_temp_conversion_start, .comp_update, .irq_or_square_wave_pin_out, .irq_or_square_wave_pin_oe_n,
        .slow_clock_pin_out, .slow_clock_pin_oe_n);
    rcs_core_model model (.sys_clk, .resetn, .slow_done, .supply_insufficient, .osc_enable, .temp_force_temp_conversion_start,
        .osc_running, .temp_force_temp_conversion_done, .one_hz_wave, .slow_clock_wave);

    // clock and compensation pulse count
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (comp_update === 1'h1) comps++;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        reg_wr_en = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        cyc(1);
        reg_wr_en = 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        cyc(1);
        reg_rd_en = 1'h1;
        reg_addr = a;
        cyc(1);
        reg_rd_en = 1'h0;
        rv = reg_rdata;
    endtask : rd
    task automatic tick(input logic m1, input logic m2, input logic t);
        cyc(1);
        update_tick = t;
        first_alarm_match = m1;
        second_alarm_match = m2;
        cyc(1);
        {update_tick, first_alarm_match, second_alarm_match} = 3'h0;
    endtask : tick

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(8'h0E); chk(rv, 8'h1C);
        rd(8'h0F); chk(rv, 8'h88);
        rd(8'h10); chk(rv, 8'h00);
        wr(8'h0F, 8'h08); rd(8'h0F); chk(rv, 8'h08);
        supply_insufficient = 1'h1;
        cyc(6);
        supply_insufficient = 1'h0;
        cyc(6);
        rd(8'h0F); chk(rv, 8'h88);
        wr(8'h0F, 8'h08);
        wr(8'h0E, 8'h1C ^ 8'h18); rd(8'h0E); chk(rv, 8'h04);
    endtask : t_reset
    task automatic t_alarm(input int i, input logic ie);
        logic [7:0] f;
        f = 8'h01 << i;
        wr(8'h0E, 8'h04 | (ie ? f : 8'h00));
        tick(i == 0, i == 1, 1'h0);
        rd(8'h0F); chk(rv, 8'h08);
        tick(i == 0, i == 1, 1'h1);
        cyc(2);
        chk(8'(irq_or_square_wave_pin_oe_n), 8'(!ie));
        rd(8'h0F); chk(rv, 8'h08 | f);
        wr(8'h0F, 8'h0B); rd(8'h0F); chk(rv, 8'h08 | f);
        wr(8'h0F, 8'h08);
        cyc(2);
        chk(8'(irq_or_square_wave_pin_oe_n), 8'h01);
    endtask : t_alarm
    task automatic t_sqw(input logic [7:0] ctl, input logic below, input logic follow);
        logic w;
        wr(8'h0E, ctl);
        main_below_pf = below;
        cyc(5);
        repeat (10) begin
            w = one_hz_wave;
            cyc(1);
            chk({irq_or_square_wave_pin_out, 7'(irq_or_square_wave_pin_oe_n)}, 8'(follow ? w : 1'h1));
        end
        main_below_pf = 1'h0;
    endtask : t_sqw
    task automatic t_force_temp_conversion(input logic slow);
        slow_done = slow;
        wr(8'h0E, 8'h24);
        rd(8'h0E); chk(rv, 8'h24);
        rd(8'h0F); chk(rv, 8'h0C);
        periodic_force_temp_conversion_req = slow;
        cyc(1);
        periodic_force_temp_conversion_req = 1'h0;
        rd(8'h0E);
        for (int k = 0; k < 40 && rv[5] !== 1'h0; k++) rd(8'h0E);
        chk(rv, 8'h04);
        rd(8'h0F); chk(rv, slow ? 8'h0C : 8'h08);
    endtask : t_force_temp_conversion
    task automatic t_osc();
        wr(8'h0E, 8'h84);
        cyc(6);
        chk(8'(osc_enable), 8'h01);
        on_backup_supply = 1'h1;
        cyc(8);
        chk({6'h00, osc_enable, counters_hold}, 8'h01);
        tick(1'h1, 1'h1, 1'h1);
        on_backup_supply = 1'h0;
        cyc(8);
        rd(8'h0F); chk(rv, 8'h88);
        chk(8'(counters_hold), 8'h00);
        wr(8'h0F, 8'h00);
        cyc(2);
        chk(8'(slow_clock_pin_oe_n), 8'h01);
        wr(8'h0F, 8'h08);
        cyc(2);
        chk(8'(slow_clock_pin_oe_n), 8'h00);
    endtask : t_osc

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // main sequence
    initial begin
        cyc(12);
        resetn = 1'h1;
        t_reset();
        for (int i = 0; i < 4; i++) t_alarm(i / 2, i[0]);
        t_sqw(8'h00, 1'h0, 1'h1);
        t_sqw(8'h00, 1'h1, 1'h0);
        t_sqw(8'h40, 1'h1, 1'h1);
        t_force_temp_conversion(1'h0);
        cyc(4);
        chk(8'(comps), 8'h01);
        t_force_temp_conversion(1'h1);
        cyc(6);
        chk(8'(comps), 8'h01);
        tick(1'h0, 1'h0, 1'h1);
        cyc(6);
        chk(8'(comps), 8'h02);
        t_osc();
        results();
    end

    // watchdog
    initial begin
        #2000000;
        bad_count++;
        results();
    end
endmodule : rcs_regs_test
